// ### design/asp_pkg.sv
// Constants for the 8/9-bit asynchronous serial port
package asp_pkg;
  localparam logic [7:0] ASP_CTRL_ADDR = 8'h98;
  localparam logic [7:0] ASP_DATA_ADDR = 8'h99;
  localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
  localparam int ASP_BIT_MODE = 7;
  localparam int ASP_BIT_UNUSED = 6;
  localparam int ASP_BIT_QUAL = 5;
  localparam int ASP_BIT_REN = 4;
  localparam int ASP_BIT_TB8 = 3;
  localparam int ASP_BIT_RB8 = 2;
  localparam int ASP_BIT_TDONE = 1;
  localparam int ASP_BIT_RDONE = 0;
  localparam logic [3:0] ASP_DATA_BITS = 4'h8;
  localparam logic [4:0] ASP_TICKS_PER_BIT = 5'h02;
  localparam logic [4:0] ASP_TICKS_HALF = 5'h01;
  typedef enum logic [2:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_NINTH, ASP_STOP} asp_phase_t;
endpackage

// ### design/asp_tx.sv
// Transmit shifter
`timescale 1ns/100ps
`default_nettype none
module asp_tx
  import asp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic [7:0] data_in,
  input wire logic nine_in,
  input wire logic ninth_in,
  output logic pin_out,
  output logic done_out
);
  asp_phase_t st_q;
  logic [7:0] sh_q;
  logic ninth_q;
  logic nine_q;
  logic [3:0] cnt_q;
  logic half_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ASP_IDLE;
      sh_q <= 8'h00;
      ninth_q <= 1'b0;
      nine_q <= 1'b0;
      cnt_q <= 4'h0;
      half_q <= 1'b0;
      pin_out <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (load_in) begin
        // A new write restarts the frame; the old byte is abandoned
        st_q <= ASP_START;
        sh_q <= data_in;
        ninth_q <= ninth_in;
        nine_q <= nine_in;
        half_q <= 1'b0;
        cnt_q <= 4'h0;
      end else if (tick_in && st_q != ASP_IDLE) begin
        half_q <= ~half_q;
        if (half_q) begin
          case (st_q)
            ASP_START: begin
              pin_out <= 1'b0;
              st_q <= ASP_DATA;
            end
            ASP_DATA: begin
              pin_out <= sh_q[0];
              sh_q <= {1'b0, sh_q[7:1]};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == ASP_DATA_BITS - 4'h1) begin
                st_q <= nine_q ? ASP_NINTH : ASP_STOP;
              end
            end
            ASP_NINTH: begin
              pin_out <= ninth_q;
              st_q <= ASP_STOP;
            end
            ASP_STOP: begin
              pin_out <= 1'b1;
              done_out <= 1'b1;
              st_q <= ASP_IDLE;
            end
            default: st_q <= ASP_IDLE;
          endcase
        end
      end
    end
  end
  // Stop bit stays high through idle; next frame's start bit waits for the second tick after the write
endmodule // asp_tx
`default_nettype wire

// ### design/asp_rx.sv
// Receive sampler
`timescale 1ns/100ps
`default_nettype none
module asp_rx
  import asp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic pin_in,
  input wire logic en_in,
  input wire logic nine_in,
  output logic done_out,
  output logic [7:0] data_out,
  output logic ninth_out,
  output logic stop_out
);
  asp_phase_t st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [4:0] tk_q;
  logic nine_q;
  logic at_q;
  logic prev_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ASP_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      tk_q <= 5'h00;
      nine_q <= 1'b0;
      at_q <= 1'b0;
      prev_q <= 1'b1;
      done_out <= 1'b0;
      data_out <= 8'h00;
      ninth_out <= 1'b0;
      stop_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      at_q <= 1'b0;
      // Previous level resets high so that reset cannot look like a start
      prev_q <= pin_in;
      if (st_q == ASP_IDLE) begin
        // Edge, not level: a low stop bit must not open a phantom frame
        if (en_in && prev_q && !pin_in) begin
          // Timer realigned to the falling edge, sample at mid bit
          st_q <= ASP_START;
          tk_q <= 5'h00;
          nine_q <= nine_in;
        end
      end else if (tick_in) begin
        at_q <= (tk_q == ASP_TICKS_HALF - 5'h01);
        tk_q <= (tk_q == ASP_TICKS_PER_BIT - 5'h01) ? 5'h00 : tk_q + 5'h01;
      end
      if (at_q) begin
        case (st_q)
          ASP_START: begin
            st_q <= pin_in ? ASP_IDLE : ASP_DATA;
            cnt_q <= 4'h0;
          end
          ASP_DATA: begin
            sh_q <= {pin_in, sh_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == ASP_DATA_BITS - 4'h1) begin
              st_q <= nine_q ? ASP_NINTH : ASP_STOP;
            end
          end
          ASP_NINTH: begin
            ninth_out <= pin_in;
            st_q <= ASP_STOP;
          end
          ASP_STOP: begin
            stop_out <= pin_in;
            data_out <= sh_q;
            done_out <= 1'b1;
            st_q <= ASP_IDLE;
          end
          default: st_q <= ASP_IDLE;
        endcase
      end
    end
  end
endmodule // asp_rx
`default_nettype wire

// ### design/asp_top.sv
// Serial port top: control register, data port, pin sync
`timescale 1ns/100ps
`default_nettype none
module asp_top
  import asp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic baud_tick_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_page1_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic bit_wr_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic bit_val_in,
  input wire logic int_enable_in,
  input wire logic serial_in_pin_in,
  output logic [7:0] sfr_rdata_out,
  output logic serial_out_pin_out,
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q;
  logic [7:0] rbuf_q;
  logic s1_q;
  logic s2_q;
  logic tx_done;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_stop;
  logic sel_ctrl;
  logic sel_data;
  logic [7:0] ctrl_wv;
  logic ctrl_we;
  logic accept;
  logic qual_ok;
  assign sel_ctrl = sfr_page1_in && sfr_addr_in == ASP_CTRL_ADDR;
  assign sel_data = sfr_page1_in && sfr_addr_in == ASP_DATA_ADDR;
  // Pin passes two flops before the receiver looks at it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= serial_in_pin_in;
      s2_q <= s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Bit writes merge with the current value, byte writes replace it
  always_comb begin
    ctrl_wv = ctrl_q;
    ctrl_we = 1'b0;
    if (sel_ctrl && sfr_wr_in) begin
      ctrl_wv = sfr_wdata_in;
      ctrl_we = 1'b1;
    end else if (sel_ctrl && bit_wr_in) begin
      ctrl_wv[bit_sel_in] = bit_val_in;
      ctrl_we = 1'b1;
    end
  end
  assign qual_ok = !ctrl_q[ASP_BIT_QUAL] ||
    (ctrl_q[ASP_BIT_MODE] ? rx_ninth : rx_stop);
  assign accept = rx_done && !ctrl_q[ASP_BIT_RDONE] && qual_ok;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= ASP_CTRL_RESET;
    end else begin
      if (ctrl_we) begin
        ctrl_q <= ctrl_wv;
      end
      ctrl_q[ASP_BIT_UNUSED] <= 1'b1;
      // Hardware set wins over a same-cycle software clear
      if (tx_done) begin
        ctrl_q[ASP_BIT_TDONE] <= 1'b1;
      end
      if (accept) begin
        ctrl_q[ASP_BIT_RDONE] <= 1'b1;
        ctrl_q[ASP_BIT_RB8] <= ctrl_q[ASP_BIT_MODE] ? rx_ninth : rx_stop;
      end
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rbuf_q <= 8'h00;
    end else if (accept) begin
      rbuf_q <= rx_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sfr_rdata_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      sfr_rdata_out <= 8'h00;
      if (sfr_rd_in && sel_ctrl) begin
        sfr_rdata_out <= ctrl_q;
      end else if (sfr_rd_in && sel_data) begin
        sfr_rdata_out <= rbuf_q;
      end
      irq_out <= int_enable_in &&
        (ctrl_q[ASP_BIT_TDONE] || ctrl_q[ASP_BIT_RDONE]);
    end
  end
  asp_tx u_tx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(baud_tick_in),
    .load_in(sel_data && sfr_wr_in),
    .data_in(sfr_wdata_in),
    .nine_in(ctrl_q[ASP_BIT_MODE]),
    .ninth_in(ctrl_q[ASP_BIT_TB8]),
    .pin_out(serial_out_pin_out),
    .done_out(tx_done)
  );
  asp_rx u_rx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(baud_tick_in),
    .pin_in(s2_q),
    .en_in(ctrl_q[ASP_BIT_REN]),
    .nine_in(ctrl_q[ASP_BIT_MODE]),
    .done_out(rx_done),
    .data_out(rx_data),
    .ninth_out(rx_ninth),
    .stop_out(rx_stop)
  );
endmodule // asp_top
`default_nettype wire

// ### tb/asp_chk.sv
// Port checker for the serial port top
`timescale 1ns/100ps
`default_nettype none
module asp_chk
  import asp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic baud_tick_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_page1_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic bit_wr_in,
  input wire logic int_enable_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic serial_out_pin_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  a_reset_idle: assert property ($fell(rst_in) |-> serial_out_pin_out && !irq_out)
    else $error("Line or irq not idle after reset");
  a_irq_needs_en: assert property (irq_out |-> $past(int_enable_in))
    else $error("Irq without enable");
  a_irq_drops: assert property (!int_enable_in |=> !irq_out)
    else $error("Irq stays after enable dropped");
  // Only software writes may clear the flags behind irq
  a_irq_holds: assert property (irq_out && int_enable_in && !sfr_wr_in && !bit_wr_in
    && !$past(sfr_wr_in) && !$past(bit_wr_in) |=> irq_out)
    else $error("Irq fell with no software write");
  a_rd_idle: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
    else $error("Read data not zero without read");
  a_bit6_reads: assert property (sfr_rd_in && sfr_page1_in && sfr_addr_in == ASP_CTRL_ADDR
    |=> sfr_rdata_out[6])
    else $error("Control bit 6 read as 0");
  a_rd_unmapped: assert property (sfr_rd_in && (!sfr_page1_in || sfr_addr_in != ASP_CTRL_ADDR
    && sfr_addr_in != ASP_DATA_ADDR) |=> sfr_rdata_out == 8'h00)
    else $error("Unmapped read not zero");
  a_pin_on_tick: assert property ($changed(serial_out_pin_out) |-> $past(baud_tick_in))
    else $error("Transmit line moved off a baud tick");
  c_irq: cover property ($rose(irq_out));
  c_start: cover property ($fell(serial_out_pin_out));
  c_rdone: cover property (sfr_rd_in && sfr_addr_in == ASP_CTRL_ADDR ##1 sfr_rdata_out[0]);
endmodule // asp_chk
bind asp_top asp_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .baud_tick_in(baud_tick_in),
  .sfr_addr_in(sfr_addr_in), .sfr_page1_in(sfr_page1_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .bit_wr_in(bit_wr_in), .int_enable_in(int_enable_in),
  .sfr_rdata_out(sfr_rdata_out), .serial_out_pin_out(serial_out_pin_out), .irq_out(irq_out));
`default_nettype wire

// ### tb/asp_remote.sv
// Remote serial port model facing the device pins
`timescale 1ns/100ps
`default_nettype none
module asp_remote #(parameter int BIT = 8) (
  input wire logic clk_in,
  input wire logic tick_in,
  input wire logic nine_in,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_byte;
  logic got_ninth;
  logic got_stop;
  int got_cnt = 0;
  initial line_out = 1'b1;
  // Mid-bit sampling tolerates a few cycles of skew
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_in);
      got_byte[i] = line_in;
    end
    if (nine_in) begin
      repeat (BIT) @(posedge clk_in);
      got_ninth = line_in;
    end
    repeat (BIT) @(posedge clk_in);
    got_stop = line_in;
    got_cnt++;
  end
  ////////////////////////////////////////
  // Ninth bit 1 marks an address, 0 data; a low stop is sent only on request
  task automatic send(input logic [7:0] b, input logic b9, input logic stp);
    logic [10:0] f;
    f = nine_in ? {stp, b9, b, 1'b0} : {1'b1, stp, b, 1'b0};
    @(posedge clk_in iff tick_in);
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask
endmodule // asp_remote
`default_nettype wire

// ### tb/asp_top_test.sv
// Self-checking bench for the serial port top
`timescale 1ns/100ps
`default_nettype none
module asp_top_test;
  import asp_pkg::*;
  typedef struct packed {logic m9; logic qual; logic [7:0] b; logic b9; logic acc;} asp_row_t;
  asp_row_t rows [6] = '{'{1'b0, 1'b0, 8'ha5, 1'b1, 1'b1}, '{1'b0, 1'b1, 8'h3c, 1'b0, 1'b0},
    '{1'b0, 1'b0, 8'h81, 1'b0, 1'b1}, '{1'b1, 1'b1, 8'h5a, 1'b1, 1'b1},
    '{1'b1, 1'b1, 8'h66, 1'b0, 1'b0}, '{1'b1, 1'b0, 8'h0f, 1'b0, 1'b1}};
  logic clk_in = 0, rst_in = 1, tick = 0, pg = 1, wr_s = 0, rd_s = 0, bw_s = 0, bv = 0;
  logic ien = 0, m9 = 0, txp, rxp, irq;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdata;
  logic [2:0] bsel = 3'h0;
  int fails = 0, num_checks = 0, tcnt = 0, nf = 0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    tcnt <= (tcnt + 1) % 4;
    tick <= (tcnt == 3);
  end
  asp_top uut (.clk_in(clk_in), .rst_in(rst_in), .baud_tick_in(tick), .sfr_addr_in(addr),
    .sfr_page1_in(pg), .sfr_wr_in(wr_s), .sfr_rd_in(rd_s), .sfr_wdata_in(wdat),
    .bit_wr_in(bw_s), .bit_sel_in(bsel), .bit_val_in(bv), .int_enable_in(ien),
    .serial_in_pin_in(rxp), .sfr_rdata_out(rdata), .serial_out_pin_out(txp), .irq_out(irq));
  asp_remote #(.BIT(8)) rp (.clk_in(clk_in), .tick_in(tick), .nine_in(m9), .line_in(txp),
    .line_out(rxp));
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic wait_tx;
    int k;
    k = 0;
    nf++;
    while (rp.got_cnt != nf && k < 300) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 300) begin
      fails++;
      $display("[ERR] tx frames expected %0d seen %0d", nf, rp.got_cnt);
      give_verdict();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk("pin", 8'h01, {7'h00, txp});
    rd("ctrl", ASP_CTRL_ADDR, ASP_CTRL_RESET);
    rd("data", ASP_DATA_ADDR, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      m9 = rows[i].m9;
      wr(ASP_CTRL_ADDR, {rows[i].m9, 1'b0, rows[i].qual, 1'b1, rows[i].b9, 3'h0});
      rp.send(rows[i].b, rows[i].b9, rows[i].m9 | rows[i].b9);
      wr(ASP_DATA_ADDR, ~rows[i].b);
      wait_tx();
      chk("tx byte", ~rows[i].b, rp.got_byte);
      chk("tx stop", 8'h01, {7'h00, rp.got_stop});
      if (rows[i].m9) chk("tx ninth", {7'h00, rows[i].b9}, {7'h00, rp.got_ninth});
      rd("ctrl", ASP_CTRL_ADDR, {rows[i].m9, 1'b1, rows[i].qual, 1'b1, rows[i].b9,
        rows[i].acc & rows[i].b9, 1'b1, rows[i].acc});
      if (rows[i].acc) rd("rx data", ASP_DATA_ADDR, rows[i].b);
      else rd("rx kept", ASP_DATA_ADDR, rows[i - 1].b);
      $display("row %0d done", i);
    end
    m9 = 1'b0;
    @(posedge clk_in);
    ien <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("irq set", 8'h01, {7'h00, irq});
    wr(ASP_CTRL_ADDR, 8'h10);
    repeat (3) @(posedge clk_in);
    chk("irq clear", 8'h00, {7'h00, irq});
    rp.send(8'h11, 1'b0, 1'b1);
    rp.send(8'h22, 1'b0, 1'b1);
    rd("overrun", ASP_DATA_ADDR, 8'h11);
    chk("irq rx", 8'h01, {7'h00, irq});
    @(posedge clk_in);
    bsel <= 3'h0;
    bv <= 1'b0;
    bw_s <= 1'b1;
    addr <= ASP_CTRL_ADDR;
    @(posedge clk_in);
    bw_s <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("irq bit clear", 8'h00, {7'h00, irq});
    $display("overrun test done");
    // Slave side: address taken, qualify dropped for data, then raised again
    m9 = 1'b1;
    wr(ASP_CTRL_ADDR, 8'hb0);
    rp.send(8'h42, 1'b1, 1'b1);
    rd("mp addr", ASP_DATA_ADDR, 8'h42);
    wr(ASP_CTRL_ADDR, 8'h90);
    rp.send(8'h24, 1'b0, 1'b1);
    rd("mp data", ASP_DATA_ADDR, 8'h24);
    wr(ASP_CTRL_ADDR, 8'hb0);
    rp.send(8'h99, 1'b0, 1'b1);
    rd("mp ignored", ASP_DATA_ADDR, 8'h24);
    m9 = 1'b0;
    $display("multiprocessor test done");
    wr(ASP_CTRL_ADDR, 8'h00);
    rp.send(8'h77, 1'b0, 1'b1);
    wr(8'h97, 8'hff);
    rd("unmapped", 8'h97, 8'h00);
    rd("rx off", ASP_CTRL_ADDR, 8'h40);
    @(posedge clk_in);
    pg <= 1'b0;
    rd("page0", ASP_CTRL_ADDR, 8'h00);
    $display("disable test done");
    give_verdict();
  end
endmodule // asp_top_test
`default_nettype wire
